// ### hw/pmcs_top.sv
// Power mode control and system clock source switching.
// Assumes a CPU core writing 8-bit registers on core_clk, and oscillator
// enables and clock gates built outside from the levels given here.
//
// What this block does
// [RL1] Idle request halts CPU clock; CPU state and pins stay frozen.
// [RL2] Peripheral clocks keep running in idle so interrupts can wake.
// [RL3] The idle-setting write is the last instruction before idle.
// [RL4] Interrupt exit clears idle bit; execution resumes after entry.
// [RL5] Any reset but software reset ends idle.
// [RL6] Software sets watchdog run-in-idle before relying on watchdog wake.
// [RL7] Power-down request stops system clock, peripherals, puts flash to stop.
// [RL8] RAM and pin drive values hold during power-down.
// [RL9] Any reset but software reset ends power-down; pin/power resets restart.
// [RL10] External interrupt restarts clock; service after oscillator stable.
// [RL11] External, pin, watchdog, wake timer, brown-out interrupts wake.
// [RL12] Sources: 16 MHz fast, 10 kHz slow, external clock pin.
// [RL13] Fast oscillator enable bit; slow oscillator always runs.
// [RL14] After power-up both internals run and fast one is selected.
// [RL15] External clock pin is ordinary I/O unless the external input is enabled.
// [RL16] Clock switch and enable writes need timed access.
// [RL17] Software enables target, polls stable, then switches source.
// [RL18] Disabling the active oscillator is ignored entirely.
// [RL19] Selecting a disabled source updates field, sets fault, keeps clock.
// [RL20] Unstable target: fault set, switch when stable, then fault clears.
// [RL21] Status bits 5, 4, 3 show fast, slow, external enabled and stable.
// [RL22] Select field bits 2:1: 00 fast, 01 ext, 10 slow, 11 reserved.
// [RL23] Software writes key 0xaa then 0x55 before protected writes.
// [RL24] Fault flag is bit 0 of clock enable register.
// [RL25] External clock enabled only when its field equals 11.
// [RL26] Idle and power-down together enter power-down only.
module pmcs_top
  import pmcs_pkg::*;
#(
  parameter int FAST_SETTLE = 32,
  parameter int SLOW_SETTLE = 4,
  parameter int EXT_SETTLE = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sw_reset,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic wake_ext_irq,
  input wire logic wake_pin_irq,
  input wire logic wake_wdt_irq,
  input wire logic wake_timer_irq,
  input wire logic wake_brownout_irq,
  input wire logic wake_other_irq,
  input wire logic ext_clock_pin,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic flash_stop,
  output logic hold_outputs,
  output logic fast_osc_on,
  output logic ext_clock_on,
  output logic ext_pin_is_gpio,
  output logic [1:0] active_source
);

  // ----------------------------------------
  // Pin synchroniser and interrupt sum
  // ----------------------------------------
  logic ext_pin_s1;
  logic ext_pin_s2;
  logic ext_pin_prev;
  logic ext_edge;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_pin_s1 <= 1'b0;
      ext_pin_s2 <= 1'b0;
      ext_pin_prev <= 1'b0;
    end else begin
      ext_pin_s1 <= ext_clock_pin;
      ext_pin_s2 <= ext_pin_s1;
      ext_pin_prev <= ext_pin_s2;
    end
  end
  assign ext_edge = ext_pin_s2 ^ ext_pin_prev;

  // [RL11] Power-down wake sources.
  wire down_wake = wake_ext_irq | wake_pin_irq | wake_wdt_irq |
                   wake_timer_irq | wake_brownout_irq;
  // [RL2] Any enabled interrupt wakes idle.
  wire idle_wake = down_wake | wake_other_irq;

  // ----------------------------------------
  // Timed-access key
  // ----------------------------------------
  logic [1:0] key_stage;
  logic [1:0] key_timer;
  wire wr_key = reg_wr && reg_addr == ADDR_TIMED_KEY;
  wire wr_sw = reg_wr && reg_addr == ADDR_CLOCK_SWITCH;
  wire wr_en = reg_wr && reg_addr == ADDR_CLOCK_ENABLE;
  wire wr_pc = reg_wr && reg_addr == ADDR_POWER_CONTROL;
  wire unlocked = key_stage == 2'h2;
  // [RL16] Protected writes pass only while unlocked.
  wire ok_sw = wr_sw && unlocked;
  wire ok_en = wr_en && unlocked;

  // [RL23] Key sequence opens a short window.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      key_stage <= 2'h0;
      key_timer <= 2'h0;
    end else if (wr_key && reg_wdata == KEY_FIRST) begin
      key_stage <= 2'h1;
      key_timer <= KEY_WINDOW;
    end else if (wr_key && key_stage == 2'h1 && reg_wdata == KEY_SECOND) begin
      key_stage <= 2'h2;
      key_timer <= KEY_WINDOW;
    end else if (wr_sw || wr_en || wr_key || key_timer == 2'h0) begin
      key_stage <= 2'h0;
      key_timer <= 2'h0;
    end else begin
      key_timer <= key_timer - 2'h1;
    end
  end

  // ----------------------------------------
  // Oscillator enables and status
  // ----------------------------------------
  logic fast_en;
  logic [1:0] ext_field;
  logic fast_st;
  logic slow_st;
  logic ext_st;
  logic [1:0] sel_field;
  logic [1:0] cur_src;
  logic fault;
  pmcs_state_t state;

  // [RL25] External input on only for code 11.
  wire ext_on = ext_field == EXT_ON_CODE;
  // [RL10] Fast oscillator halts in power-down until a wake.
  wire osc_run = state != PMCS_DOWN || down_wake;
  wire [1:0] new_ext = reg_wdata[EXT_EN_LO +: 2];
  wire new_fast = reg_wdata[FAST_EN_BIT];
  // [RL18] Refuse to turn off the running source.
  wire kills_cur = (cur_src == PMCS_SRC_FAST && !new_fast) ||
                   (cur_src == PMCS_SRC_EXT && new_ext != EXT_ON_CODE);

  // [RL13] Fast oscillator enable; slow always on.
  // [RL14] Both internals on after reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fast_en <= CLOCK_ENABLE_RESET[FAST_EN_BIT];
      ext_field <= CLOCK_ENABLE_RESET[EXT_EN_LO +: 2];
    end else if (ok_en && !kills_cur) begin
      fast_en <= new_fast;
      ext_field <= new_ext;
    end
  end

  // [RL12] Settling counters for the three sources.
  pmcs_settle #(.COUNT(FAST_SETTLE)) u_fast (
    .core_clk(core_clk), .rst(rst), .enable(fast_en && osc_run),
    .ready(fast_st));
  pmcs_settle #(.COUNT(SLOW_SETTLE)) u_slow (
    .core_clk(core_clk), .rst(rst), .enable(1'b1), .ready(slow_st));
  wire ext_live = ext_on && ext_edge;
  logic ext_seen;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_seen <= 1'b0;
    end else begin
      ext_seen <= ext_on && (ext_seen || ext_live);
    end
  end
  pmcs_settle #(.COUNT(EXT_SETTLE)) u_ext (
    .core_clk(core_clk), .rst(rst), .enable(ext_seen), .ready(ext_st));

  function automatic logic src_ready(input logic [1:0] s, input logic f,
                                     input logic l, input logic e);
    case (s)
      PMCS_SRC_FAST: src_ready = f;
      PMCS_SRC_EXT: src_ready = e;
      PMCS_SRC_SLOW: src_ready = l;
      default: src_ready = 1'b0;
    endcase
  endfunction

  function automatic logic src_enabled(input logic [1:0] s, input logic f,
                                       input logic e);
    case (s)
      PMCS_SRC_FAST: src_enabled = f;
      PMCS_SRC_EXT: src_enabled = e;
      PMCS_SRC_SLOW: src_enabled = 1'b1;
      default: src_enabled = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Source selection and switch fault
  // ----------------------------------------
  wire [1:0] new_sel = reg_wdata[SEL_LO +: 2];
  wire tgt_ready = src_ready(sel_field, fast_st, slow_st, ext_st);
  wire tgt_enabled = src_enabled(sel_field, fast_en, ext_on);
  wire pending = sel_field != cur_src;
  // An enable write in the same cycle defers the switch, so a source
  // cannot become current while it is being turned off.
  wire do_switch = !ok_sw && !ok_en && pending && tgt_enabled && tgt_ready;

  // [RL22] Select field written at bits 2:1.
  // [RL19] Field updates at once even if target disabled.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_field <= CLOCK_SWITCH_RESET[SEL_LO +: 2];
      cur_src <= PMCS_SRC_FAST;
    end else begin
      if (ok_sw) begin
        sel_field <= new_sel;
      end
      // [RL20] Background switch once target is stable.
      if (do_switch) begin
        cur_src <= sel_field;
      end
    end
  end

  // [RL24] Fault flag set by bad switch, cleared on success.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault <= 1'b0;
    end else if (ok_sw) begin
      fault <= new_sel != cur_src &&
               !(src_enabled(new_sel, fast_en, ext_on) &&
                 src_ready(new_sel, fast_st, slow_st, ext_st));
    end else if (do_switch) begin
      fault <= 1'b0;
    end
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  pmcs_state_t next_state;
  logic idle_bit;
  logic down_bit;
  wire src_ok = src_ready(cur_src, fast_st, slow_st, ext_st);

  always_comb begin
    next_state = state;
    case (state)
      PMCS_RUN: begin
        // [RL26] Power-down wins when both bits set.
        if (wr_pc && reg_wdata[PDOWN_BIT]) begin
          next_state = PMCS_DOWN;
        end else if (wr_pc && reg_wdata[IDLE_BIT]) begin
          next_state = PMCS_IDLE;
        end
      end
      PMCS_IDLE: begin
        // [RL4] Interrupt releases idle.
        if (idle_wake) begin
          next_state = PMCS_RUN;
        end
      end
      PMCS_DOWN: begin
        // [RL10] Resume only after the clock source is stable.
        if (down_wake && src_ok) begin
          next_state = PMCS_RUN;
        end
      end
      default: next_state = PMCS_RUN;
    endcase
  end

  // [RL5] Software reset does not touch power state; others use rst.
  // [RL9] Reset leaves power-down and restarts the program.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= PMCS_RUN;
      idle_bit <= 1'b0;
      down_bit <= 1'b0;
    end else begin
      state <= next_state;
      if (state == PMCS_RUN && wr_pc) begin
        idle_bit <= reg_wdata[IDLE_BIT] & ~reg_wdata[PDOWN_BIT];
        down_bit <= reg_wdata[PDOWN_BIT];
      end else if (next_state == PMCS_RUN && state != PMCS_RUN) begin
        idle_bit <= 1'b0;
        down_bit <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Outputs and readback
  // ----------------------------------------
  // [RL21] Status bits, [RL24] fault at bit 0, reserved bits read zero.
  wire [7:0] sw_view = {2'h0, fast_st && fast_en, slow_st,
                        ext_st && ext_on, sel_field, 1'b0};
  wire [7:0] en_view = {ext_field, fast_en, 4'h0, fault};
  wire [7:0] pc_view = {6'h0, down_bit, idle_bit};
  wire [7:0] next_rdata = reg_addr == ADDR_CLOCK_SWITCH ? sw_view :
                          reg_addr == ADDR_CLOCK_ENABLE ? en_view :
                          reg_addr == ADDR_POWER_CONTROL ? pc_view : 8'h00;

  // [RL1] [RL3] Write takes effect after its own cycle, halting the CPU.
  // [RL7] Power-down stops peripherals, flash and the fast and external sources; slow keeps running.
  // [RL8] Pins hold their values while not running.
  // [RL15] Pin is plain I/O unless the external input is on.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      flash_stop <= 1'b0;
      hold_outputs <= 1'b0;
      fast_osc_on <= 1'b1;
      ext_clock_on <= 1'b0;
      ext_pin_is_gpio <= 1'b1;
      active_source <= PMCS_SRC_FAST;
    end else begin
      reg_rdata <= next_rdata;
      cpu_clk_en <= next_state == PMCS_RUN;
      periph_clk_en <= next_state != PMCS_DOWN;
      flash_stop <= next_state == PMCS_DOWN;
      hold_outputs <= next_state != PMCS_RUN;
      fast_osc_on <= fast_en && (next_state != PMCS_DOWN || down_wake);
      ext_clock_on <= ext_on && next_state != PMCS_DOWN;
      ext_pin_is_gpio <= !ext_on;
      active_source <= cur_src;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_idle_entry_halt: assert property ( // [RL1]
    @(posedge core_clk) disable iff (rst)
    state == PMCS_RUN && wr_pc && reg_wdata[IDLE_BIT] &&
    !reg_wdata[PDOWN_BIT] |=> !cpu_clk_en && periph_clk_en)
    else $error("idle entry did not halt cpu clock");

  a_down_wins: assert property ( // [RL26]
    @(posedge core_clk) disable iff (rst)
    state == PMCS_RUN && wr_pc && reg_wdata[PDOWN_BIT] |=>
    state == PMCS_DOWN && flash_stop && !periph_clk_en)
    else $error("power-down did not win");

  a_idle_exit_clear: assert property ( // [RL4]
    @(posedge core_clk) disable iff (rst)
    state == PMCS_IDLE && idle_wake |=> state == PMCS_RUN && !idle_bit)
    else $error("idle exit did not clear bit");

  a_down_wait_stable: assert property ( // [RL10]
    @(posedge core_clk) disable iff (rst)
    state == PMCS_DOWN && !src_ok |=> state == PMCS_DOWN)
    else $error("left power-down before source stable");

  a_locked_ignored: assert property ( // [RL16]
    @(posedge core_clk) disable iff (rst)
    wr_en && !unlocked |=> $stable(fast_en) && $stable(ext_field))
    else $error("locked write changed enables");

  a_keep_current: assert property ( // [RL18]
    @(posedge core_clk) disable iff (rst)
    cur_src == PMCS_SRC_FAST |-> fast_en)
    else $error("active fast oscillator disabled");

  a_bad_switch_flag: assert property ( // [RL19]
    @(posedge core_clk) disable iff (rst)
    ok_sw && new_sel != cur_src &&
    !src_enabled(new_sel, fast_en, ext_on) |=>
    fault && sel_field == $past(new_sel) && cur_src == $past(cur_src))
    else $error("switch to disabled source mishandled");

  a_switch_clears: assert property ( // [RL20]
    @(posedge core_clk) disable iff (rst)
    do_switch |=>
    cur_src == $past(sel_field) && !fault)
    else $error("background switch did not complete");

  a_ext_code: assert property ( // [RL25]
    @(posedge core_clk) disable iff (rst)
    ext_field != EXT_ON_CODE |=> ext_pin_is_gpio && !ext_clock_on)
    else $error("external input on with wrong code");

endmodule // pmcs_top

// ### include/pmcs_pkg.sv
// Package for the power mode and clock switch block.
// Assumes an 8-bit special function register port from the CPU core.
package pmcs_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_TIMED_KEY = 8'hc7;
  localparam logic [7:0] ADDR_CLOCK_SWITCH = 8'h96;
  localparam logic [7:0] ADDR_CLOCK_ENABLE = 8'h97;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int IDLE_BIT = 0;
  localparam int PDOWN_BIT = 1;
  localparam int FAST_EN_BIT = 5;
  localparam int EXT_EN_LO = 6;
  localparam int SEL_LO = 1;
  localparam int FAST_ST_BIT = 5;
  localparam int SLOW_ST_BIT = 4;
  localparam int EXT_ST_BIT = 3;
  localparam int FAULT_BIT = 0;
  localparam logic [7:0] CLOCK_SWITCH_RESET = 8'h30;
  localparam logic [7:0] CLOCK_ENABLE_RESET = 8'h30;
  localparam logic [1:0] EXT_ON_CODE = 2'h3;

  // ----------------------------------------
  // Timed-access keys and window
  // ----------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [1:0] KEY_WINDOW = 2'h3;

  // ----------------------------------------
  // Source codes and oscillator rates
  // ----------------------------------------
  typedef enum logic [1:0] {
    PMCS_SRC_FAST = 2'h0,
    PMCS_SRC_EXT = 2'h1,
    PMCS_SRC_SLOW = 2'h2,
    PMCS_SRC_RSVD = 2'h3
  } pmcs_src_t;

  localparam int FAST_OSC_HZ = 16000000;
  localparam int SLOW_OSC_HZ = 10000;

  // ----------------------------------------
  // Power state codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PMCS_RUN = 3'b001,
    PMCS_IDLE = 3'b010,
    PMCS_DOWN = 3'b100
  } pmcs_state_t;

endpackage

// ### hw/pmcs_settle.sv
// Settling counter for one oscillator's stable status.
// Assumes enable is a level on core_clk; ready falls as soon as it drops.
module pmcs_settle #(
  parameter int COUNT = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  output logic ready
);
  logic [15:0] cnt;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0;
      ready <= 1'b0;
    end else if (!enable) begin
      cnt <= 16'h0;
      ready <= 1'b0;
    end else if (cnt == 16'(COUNT)) begin
      ready <= 1'b1;
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
endmodule // pmcs_settle

// ### verif/pmcs_cpu.sv
// CPU core model that writes and reads the block's registers.
// Assumes the bench calls its tasks at falling edges of core_clk.
module pmcs_cpu
  import pmcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
  endtask

  // Released data lines show the inverse of the last value.
  task automatic rest(input int n);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(a, d);
    rest(1);
  endtask

  // Key before write
  // A gap longer than the unlock window makes the write late on purpose.
  task automatic pwr(input logic [7:0] a, input logic [7:0] d,
                     input int gap);
    put(ADDR_TIMED_KEY, KEY_FIRST);
    put(ADDR_TIMED_KEY, KEY_SECOND);
    if (gap > 0) rest(gap);
    put(a, d);
    rest(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  task automatic poll(input int b, output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      rd(ADDR_CLOCK_SWITCH, v);
      ok = v[b];
    end
  endtask
endmodule // pmcs_cpu

// ### verif/tb.sv
// Self-checking bench for the power mode and clock switch block.
// Assumes the CPU model pmcs_cpu; bench inputs change at falling edges.
module tb import pmcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst, sw_reset, wake_other, ext_pin, reg_wr, ok;
  logic [4:0] wake;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, d, st;
  logic cpu_clk_en, periph_clk_en, flash_stop, hold_outputs;
  logic fast_osc_on, ext_clock_on, ext_pin_is_gpio;
  logic [1:0] active_source, m_sel, m_src;
  logic [7:0] m_en;
  logic m_fault;
  int miscompares = 0;
  int comparisons = 0;
  int codes[$] = '{1, 2, 3, 0};

  assign st = {1'b0, ext_pin_is_gpio, ext_clock_on, fast_osc_on,
               hold_outputs, flash_stop, periph_clk_en, cpu_clk_en};

  pmcs_top #(.FAST_SETTLE(16), .SLOW_SETTLE(4), .EXT_SETTLE(4)) dut (
    .core_clk(core_clk), .rst(rst), .sw_reset(sw_reset),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .wake_ext_irq(wake[0]),
    .wake_pin_irq(wake[1]), .wake_wdt_irq(wake[2]),
    .wake_timer_irq(wake[3]), .wake_brownout_irq(wake[4]),
    .wake_other_irq(wake_other), .ext_clock_pin(ext_pin),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .flash_stop(flash_stop), .hold_outputs(hold_outputs),
    .fast_osc_on(fast_osc_on), .ext_clock_on(ext_clock_on),
    .ext_pin_is_gpio(ext_pin_is_gpio), .active_source(active_source));

  pmcs_cpu cpu (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    ext_pin = 1'b0;
    forever @(negedge core_clk) ext_pin = 1'($urandom_range(1, 0));
  end

  initial begin
    #200us;
    miscompares++;
    summarize();
  end

  // ----------------------------------------
  // Checking and reference model
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  function automatic logic src_on(input logic [1:0] s);
    if (s == PMCS_SRC_FAST) return m_en[5];
    if (s == PMCS_SRC_EXT) return m_en[7:6] == EXT_ON_CODE;
    return s == PMCS_SRC_SLOW;
  endfunction

  // Unlocked write on the bus, mirrored in the model.
  task automatic cw(input logic [7:0] a, input logic [7:0] x);
    cpu.pwr(a, x, 0);
    if (a == ADDR_CLOCK_SWITCH) begin
      m_sel = x[2:1];
      m_fault = !src_on(x[2:1]);
      if (src_on(x[2:1])) m_src = x[2:1];
    end else if (!((m_src == 2'b00 && !x[5]) ||
                   (m_src == 2'b01 && x[7:6] != 2'b11))) begin
      m_en = x & 8'he0;
    end
  endtask

  task automatic cmp_regs();
    logic [7:0] e;
    e = {2'b00, m_en[5], 1'b1, m_en[7:6] == 2'b11, m_sel, 1'b0};
    cpu.rd(ADDR_CLOCK_SWITCH, v);
    check("clock_switch_reg", v, e);
    cpu.rd(ADDR_CLOCK_ENABLE, v);
    check("clock_enable_reg", v & 8'he1, m_en | 8'(m_fault));
    check("active_source", 8'(active_source), 8'(m_src));
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h7a6e));
    {m_en, m_sel, m_src, m_fault} = {8'h20, 2'b00, 2'b00, 1'b0};
    {rst, sw_reset, wake_other, wake} = {3'b100, 5'b0};
    cyc(10);
    rst = 1'b0;
    cyc(30);
    cmp_regs();
    cpu.rd(8'h55, v);
    check("unmapped", v, 8'h00);
    check("pins", st, 8'h53);
    $display("test reset done");
    cpu.wr(ADDR_CLOCK_ENABLE, 8'he0);
    cpu.pwr(ADDR_CLOCK_ENABLE, 8'he0, 4);
    cmp_regs();
    check("pins", st, 8'h53);
    $display("test protection done");
    for (int f = 0; f < 4; f++) begin
      d = {f[1:0], 1'b1, 4'($urandom), 1'b1};
      cw(ADDR_CLOCK_ENABLE, d);
      cyc(1);
      check("pins", st, {1'b0, f != 3, f == 3, 5'b10011});
      if (f == 3) begin
        cpu.poll(EXT_ST_BIT, ok);
        check("ext_stable", 8'(ok), 8'h01);
      end
      cmp_regs();
    end
    cw(ADDR_CLOCK_ENABLE, 8'hc0);
    cmp_regs();
    check("pins", st, 8'h33);
    $display("test enables done");
    foreach (codes[i]) begin
      cw(ADDR_CLOCK_SWITCH, {5'b0, codes[i][1:0], 1'b0});
      cyc(2);
      cmp_regs();
    end
    cw(ADDR_CLOCK_ENABLE, 8'h20);
    cw(ADDR_CLOCK_SWITCH, 8'h02);
    cmp_regs();
    cw(ADDR_CLOCK_SWITCH, 8'h00);
    cmp_regs();
    $display("test select done");
    cw(ADDR_CLOCK_ENABLE, 8'he0);
    cpu.poll(EXT_ST_BIT, ok);
    check("ext_stable", 8'(ok), 8'h01);
    cw(ADDR_CLOCK_SWITCH, 8'h02);
    cw(ADDR_CLOCK_ENABLE, 8'hc0);
    cmp_regs();
    cpu.pwr(ADDR_CLOCK_ENABLE, 8'he0, 0);
    cpu.pwr(ADDR_CLOCK_SWITCH, 8'h00, 0);
    cpu.rd(ADDR_CLOCK_ENABLE, v);
    check("fault_pending", v & 8'he1, 8'he1);
    check("source_pending", 8'(active_source), 8'h01);
    cyc(30);
    {m_en, m_sel, m_src, m_fault} = {8'he0, 2'b00, 2'b00, 1'b0};
    cmp_regs();
    cw(ADDR_CLOCK_ENABLE, 8'h20);
    $display("test background switch done");
    cpu.wr(ADDR_POWER_CONTROL, 8'h01);
    check("pins", st, 8'h5a);
    cpu.rd(ADDR_POWER_CONTROL, v);
    check("power_control_reg", v, 8'h01);
    sw_reset = 1'b1;
    cyc(2);
    sw_reset = 1'b0;
    check("pins", st, 8'h5a);
    wake_other = 1'b1;
    cyc(1);
    wake_other = 1'b0;
    check("pins", st, 8'h53);
    cpu.rd(ADDR_POWER_CONTROL, v);
    check("power_control_reg", v, 8'h00);
    $display("test idle done");
    for (int i = 0; i < 5; i++) begin
      cpu.wr(ADDR_POWER_CONTROL, (i == 0) ? 8'h03 : 8'h02);
      cyc(1);
      check("pins", st, 8'h4c);
      wake_other = 1'b1;
      cyc(3);
      check("pins", st, 8'h4c);
      wake_other = 1'b0;
      wake[i] = 1'b1;
      for (int n = 0; n < 100 && cpu_clk_en !== 1'b1; n++) cyc(1);
      wake = 5'b0;
      cyc(1);
      check("pins", st, 8'h53);
      cpu.rd(ADDR_POWER_CONTROL, v);
      check("power_control_reg", v, 8'h00);
    end
    $display("test power-down done");
    cpu.wr(ADDR_POWER_CONTROL, 8'h01);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    check("pins", st, 8'h53);
    cpu.rd(ADDR_POWER_CONTROL, v);
    check("power_control_reg", v, 8'h00);
    cpu.wr(ADDR_POWER_CONTROL, 8'h02);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    check("pins", st, 8'h53);
    cpu.rd(ADDR_POWER_CONTROL, v);
    check("power_control_reg", v, 8'h00);
    $display("test reset exit done");
    summarize();
  end
endmodule // tb
